/* core/alu_and_branch_exec.sv */
// Execution datapath: register file, flags, program counter
// How it works
// RQ1: Software writes reserved bits zero only
// RQ2: Bit set/clear only at I/O 0x00-0x1F
// RQ3: Skip on I/O bit for 0x00-0x1F
// RQ4: Add, add-carry: one clock, Z C N V H
// RQ5: Subtracts: one clock, Z C N V H
// RQ6: Pair add/sub immediate: two clocks, Z C N V S
// RQ7: AND, OR, XOR: one clock, Z N V
// RQ8: One's complement: 0xFF minus value, Z C N V
// RQ9: Negate: 0x00 minus value, Z C N V H
// RQ10: Mask set ORs, mask clear ANDs inverse
// RQ11: Test ANDs with itself, register unchanged
// RQ12: Clear XORs self; set-all-ones keeps flags
// RQ13: Relative jump/call: PC+k+1, 2/3 clocks
// RQ14: Indirect jump/call from Z, 2/3 clocks
// RQ15: Compare equal skips one or two words
// RQ16: Returns take four clocks; interrupt return enables
// RQ17: Increment, decrement keep carry flag
`timescale 1ns/1ps
`include "alu_regs.svh"
module alu_and_branch_exec (
  // Clock and reset
  input logic clock,
  input logic rst,
  // Instruction from the decoder
  input logic opValid,
  input alu_pkg::op_t opCode,
  input logic [4:0] dstIdx,
  input logic [4:0] srcIdx,
  input logic [7:0] immVal,
  input logic [1:0] pairSel,
  input logic [11:0] relOfs,
  input logic nextTwoWord,
  // I/O space and stack
  input logic [5:0] ioAddr,
  input logic [2:0] bitSel,
  input logic [7:0] ioRdData,
  input logic [15:0] retAddr,
  // Register read port
  input logic [4:0] regRdIdx,
  output logic [7:0] regRdData,
  // Sequencing
  output logic busy,
  output logic opDone,
  // Architectural state
  output logic [15:0] pcOut,
  output logic [7:0] statusOut,
  // Single bit I/O strobes
  output logic ioBitSetStb,
  output logic ioBitClrStb,
  output logic [5:0] ioBitAddr,
  output logic [2:0] ioBitNum,
  // Stack strobes
  output logic pushStb,
  output logic [15:0] pushAddr,
  output logic popStb
);
  import alu_pkg::*;

  // Index of one byte of a register pair
  function automatic logic [4:0] pairIdx(logic [1:0] s, logic hi);
    pairIdx = `PAIR_BASE + {2'b00, s, hi};
  endfunction

  // Operand holds an immediate instead of a register
  function automatic logic isImm(op_t o);
    isImm = (o == OP_SUB_IMMEDIATE) || (o == OP_SUB_IMM_WITH_BORROW) ||
            (o == OP_AND_IMMEDIATE) || (o == OP_OR_IMMEDIATE) ||
            (o == OP_SET_BITS_BY_MASK) || (o == OP_CLEAR_BITS_BY_MASK) ||
            (o == OP_ADD_IMM_TO_PAIR) || (o == OP_SUB_IMM_FROM_PAIR);
  endfunction

  // Sequencer state
  st_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt; // Clocks still to run
  logic busy_r, busy_nxt;
  logic done_r, done_nxt; // Last clock of an operation
  // Architectural state
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] sreg_r, sreg_nxt;
  logic [7:0] gpr_r [32];
  logic [7:0] gpr_nxt [32];
  logic [7:0] rd_r, rd_nxt;
  // Strobes towards I/O and stack
  logic ioSet_r, ioSet_nxt;
  logic ioClr_r, ioClr_nxt;
  logic [5:0] ioAddr_r, ioAddr_nxt;
  logic [2:0] ioNum_r, ioNum_nxt;
  logic push_r, push_nxt;
  logic [15:0] pushAddr_r, pushAddr_nxt;
  logic pop_r, pop_nxt;

  // Operand path
  logic take; // Operation accepted this clock
  logic isPair;
  logic [4:0] loIdx;
  logic [4:0] hiIdx;
  logic [7:0] opA;
  logic [7:0] opB;
  logic [7:0] opHi;
  logic [15:0] zPtr;
  logic [15:0] relExt;
  logic ioOk; // Address inside bit-addressable range
  logic ioBit;
  logic skipTaken;
  // Unit results
  logic [7:0] aluRes;
  logic [7:0] aluResHi;
  logic aluWr;
  logic aluWrPair;
  logic [7:0] aluFlags;
  logic [15:0] pcStep;
  logic [2:0] cycles;

  assign take = opValid && (state_r == ST_IDLE);
  assign isPair = (opCode == OP_ADD_IMM_TO_PAIR) ||
                  (opCode == OP_SUB_IMM_FROM_PAIR);
  assign loIdx = pairIdx(pairSel, 1'b0); // [RQ6]
  assign hiIdx = pairIdx(pairSel, 1'b1); // [RQ6]
  assign opA = isPair ? gpr_r[loIdx] : gpr_r[dstIdx];
  assign opHi = gpr_r[hiIdx];
  // Test feeds the register to both sides
  assign opB = (opCode == OP_TEST_ZERO_MINUS) ? opA : // [RQ11]
               (isImm(opCode) ? immVal : gpr_r[srcIdx]);
  assign zPtr = {gpr_r[`ZPTR_HI], gpr_r[`ZPTR_LO]}; // [RQ14]
  assign relExt = {{4{relOfs[11]}}, relOfs};
  assign ioOk = (ioAddr <= `IO_BIT_LAST); // [RQ2] [RQ3]
  assign ioBit = ioRdData[bitSel];

  // Skip decision for compare and bit tests
  always_comb begin
    case (opCode)
      OP_COMPARE_SKIP_EQUAL: skipTaken = (opA == opB); // [RQ15]
      OP_SKIP_IF_IO_BIT_SET: skipTaken = ioOk && ioBit; // [RQ3]
      OP_SKIP_IF_IO_BIT_CLEAR: skipTaken = ioOk && !ioBit; // [RQ3]
      default: skipTaken = 1'b0;
    endcase
  end

  // Arithmetic and flags
  alu_unit u_alu (
    .opCode(opCode),
    .a(opA),
    .b(opB),
    .aHi(opHi),
    .flagsIn(sreg_r),
    .res(aluRes),
    .resHi(aluResHi),
    .wrDst(aluWr),
    .wrPair(aluWrPair),
    .flagsOut(aluFlags)
  );

  // Program counter and clock count
  pc_unit u_pc (
    .opCode(opCode),
    .ioOk(ioOk),
    .pc(pc_r),
    .relExt(relExt),
    .zPtr(zPtr),
    .retAddr(retAddr),
    .skipTaken(skipTaken),
    .nextTwoWord(nextTwoWord),
    .pcNext(pcStep),
    .cycles(cycles)
  );

  // Next state: results commit on the accepting clock,
  // the remaining clocks only hold the sequencer busy
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    pc_nxt = pc_r;
    sreg_nxt = sreg_r;
    gpr_nxt = gpr_r;
    rd_nxt = gpr_r[regRdIdx];
    ioSet_nxt = 1'b0;
    ioClr_nxt = 1'b0;
    ioAddr_nxt = ioAddr_r;
    ioNum_nxt = ioNum_r;
    push_nxt = 1'b0;
    pushAddr_nxt = pushAddr_r;
    pop_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          pc_nxt = pcStep; // [RQ13] [RQ14] [RQ15]
          sreg_nxt = aluFlags;
          if (aluWr) begin // [RQ4] [RQ5] [RQ7]
            gpr_nxt[dstIdx] = aluRes;
          end
          if (aluWrPair) begin // [RQ6]
            gpr_nxt[loIdx] = aluRes;
            gpr_nxt[hiIdx] = aluResHi;
          end
          // Return address of the next word
          if ((opCode == OP_RELATIVE_CALL) ||
              (opCode == OP_INDIRECT_CALL)) begin // [RQ13] [RQ14]
            push_nxt = 1'b1;
            pushAddr_nxt = pc_r + `PC_STEP;
          end
          if ((opCode == OP_RETURN) ||
              (opCode == OP_INTERRUPT_RETURN)) begin // [RQ16]
            pop_nxt = 1'b1;
          end
          if (opCode == OP_INTERRUPT_RETURN) begin // [RQ16]
            sreg_nxt[`FLAG_I] = 1'b1;
          end
          // Strobes name one bit, so no other bit is
          // written back and clear-by-one flags survive
          if (ioOk && (opCode == OP_SET_IO_BIT)) begin // [RQ2]
            ioSet_nxt = 1'b1;
            ioAddr_nxt = ioAddr;
            ioNum_nxt = bitSel;
          end
          if (ioOk && (opCode == OP_CLEAR_IO_BIT)) begin // [RQ2]
            ioClr_nxt = 1'b1;
            ioAddr_nxt = ioAddr;
            ioNum_nxt = bitSel;
          end
          if (cycles == `CYC_ONE) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_WAIT;
            busy_nxt = 1'b1;
            cnt_nxt = cycles - `CYC_ONE;
          end
        end
      end
      ST_WAIT: begin // Requests are ignored here
        cnt_nxt = cnt_r - `CYC_ONE;
        if (cnt_r == `CYC_ONE) begin
          state_nxt = ST_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pc_r <= `PC_RST;
      sreg_r <= `SREG_RST;
      gpr_r <= '{default: `GPR_RST};
      rd_r <= `GPR_RST;
      ioSet_r <= 1'b0;
      ioClr_r <= 1'b0;
      ioAddr_r <= 6'h00;
      ioNum_r <= 3'h0;
      push_r <= 1'b0;
      pushAddr_r <= `PC_RST;
      pop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      pc_r <= pc_nxt;
      sreg_r <= sreg_nxt;
      gpr_r <= gpr_nxt;
      rd_r <= rd_nxt;
      ioSet_r <= ioSet_nxt;
      ioClr_r <= ioClr_nxt;
      ioAddr_r <= ioAddr_nxt;
      ioNum_r <= ioNum_nxt;
      push_r <= push_nxt;
      pushAddr_r <= pushAddr_nxt;
      pop_r <= pop_nxt;
    end
  end

  // Outputs straight from registers
  assign regRdData = rd_r;
  assign busy = busy_r;
  assign opDone = done_r;
  assign pcOut = pc_r;
  assign statusOut = sreg_r;
  assign ioBitSetStb = ioSet_r;
  assign ioBitClrStb = ioClr_r;
  assign ioBitAddr = ioAddr_r;
  assign ioBitNum = ioNum_r;
  assign pushStb = push_r;
  assign pushAddr = pushAddr_r;
  assign popStb = pop_r;

  // Checks on timing and results
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_take(op_t o);
    opValid && (state_r == ST_IDLE) && (opCode == o);
  endsequence
  sequence s_wait2;
    busy_r ##1 (done_r && !busy_r);
  endsequence

  property p_add_one;
    s_take(OP_ADD) |=> done_r && !busy_r;
  endproperty
  a_add_one: assert property (p_add_one) // [RQ4]
    else $error("add not done in one clock");
  property p_sub_one;
    s_take(OP_SUB_WITH_BORROW) |=> done_r && !busy_r;
  endproperty
  a_sub_one: assert property (p_sub_one) // [RQ5]
    else $error("subtract not done in one clock");
  property p_pair;
    s_take(OP_ADD_IMM_TO_PAIR) |=> s_wait2;
  endproperty
  a_pair: assert property (p_pair) // [RQ6]
    else $error("pair add not two clocks");
  property p_call;
    s_take(OP_RELATIVE_CALL) |=> busy_r[*2] ##1 done_r;
  endproperty
  a_call: assert property (p_call) // [RQ13]
    else $error("call not three clocks");
  property p_rel_pc;
    s_take(OP_RELATIVE_JUMP) |=>
      pc_r == $past(pc_r) + $past(relExt) + 16'h0001 ##0 s_wait2;
  endproperty
  a_rel_pc: assert property (p_rel_pc) // [RQ13]
    else $error("relative jump target or length wrong");
  property p_ind_pc;
    s_take(OP_INDIRECT_JUMP) |=> pc_r == $past(zPtr);
  endproperty
  a_ind_pc: assert property (p_ind_pc) // [RQ14]
    else $error("indirect jump target wrong");
  property p_ret;
    s_take(OP_RETURN) |=> busy_r[*3] ##1 (done_r && !busy_r);
  endproperty
  a_ret: assert property (p_ret) // [RQ16]
    else $error("return not four clocks");
  property p_interrupt_return;
    s_take(OP_INTERRUPT_RETURN) |=> sreg_r[`FLAG_I];
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) // [RQ16]
    else $error("interrupt return left enable clear");
  property p_io_range;
    (ioSet_r || ioClr_r) |-> (ioAddr_r <= `IO_BIT_LAST);
  endproperty
  a_io_range: assert property (p_io_range) // [RQ2]
    else $error("bit strobe outside low I/O range");
  property p_inc_carry;
    s_take(OP_INC) |=> sreg_r[`FLAG_C] == $past(sreg_r[`FLAG_C]);
  endproperty
  a_inc_carry: assert property (p_inc_carry) // [RQ17]
    else $error("increment changed carry");
  property p_ser_flags;
    s_take(OP_SET_REGISTER_ALL_ONES) |=> $stable(sreg_r);
  endproperty
  a_ser_flags: assert property (p_ser_flags) // [RQ12]
    else $error("set all ones changed flags");
  property p_xor_v;
    s_take(OP_EXCLUSIVE_OR) |=> !sreg_r[`FLAG_V];
  endproperty
  a_xor_v: assert property (p_xor_v) // [RQ7]
    else $error("logic op left overflow set");
endmodule

/* core/alu_pkg.sv */
// Types shared by the execution datapath
package alu_pkg;
  // Operations issued by the decoder
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMMEDIATE,
    OP_SUB_WITH_BORROW, OP_SUB_IMM_WITH_BORROW, OP_AND,
    OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR,
    OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_SET_BITS_BY_MASK,
    OP_CLEAR_BITS_BY_MASK, OP_INC, OP_DEC, OP_TEST_ZERO_MINUS,
    OP_CLEAR_REGISTER, OP_SET_REGISTER_ALL_ONES, OP_ADD_IMM_TO_PAIR,
    OP_SUB_IMM_FROM_PAIR, OP_RELATIVE_JUMP, OP_INDIRECT_JUMP,
    OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_RETURN,
    OP_INTERRUPT_RETURN, OP_COMPARE_SKIP_EQUAL, OP_SET_IO_BIT,
    OP_CLEAR_IO_BIT, OP_SKIP_IF_IO_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR
  } op_t;
  // Sequencer states
  typedef enum logic {ST_IDLE, ST_WAIT} st_t;
endpackage

/* core/alu_regs.svh */
// Constants for the execution datapath
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH
// Status bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_I 7
// Reset values
`define SREG_RST 8'h00
`define PC_RST 16'h0000
`define GPR_RST 8'h00
// Register and I/O map
`define PAIR_BASE 5'h18
`define ZPTR_LO 5'h1E
`define ZPTR_HI 5'h1F
`define IO_BIT_LAST 6'h1F
`define ALL_ONES 8'hFF
// Program counter steps
`define PC_STEP 16'h0001
`define SKIP_ONE 16'h0002
`define SKIP_TWO 16'h0003
// Clocks per instruction
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_RET 3'h4
`endif

/* core/alu_unit.sv */
// Byte and word arithmetic with status flag update
`timescale 1ns/1ps
`include "alu_regs.svh"
module alu_unit (
  // Operation
  input alu_pkg::op_t opCode,
  // Operands
  input logic [7:0] a,
  input logic [7:0] b,
  input logic [7:0] aHi,
  input logic [7:0] flagsIn,
  // Results
  output logic [7:0] res,
  output logic [7:0] resHi,
  output logic wrDst,
  output logic wrPair,
  output logic [7:0] flagsOut
);
  import alu_pkg::*;
  // Carry out of an add bit
  function automatic logic addCarry(logic x, logic y, logic r);
    addCarry = (x & y) | (y & ~r) | (~r & x);
  endfunction
  // Borrow out of a subtract bit
  function automatic logic subBorrow(logic x, logic y, logic r);
    subBorrow = (~x & y) | (y & r) | (r & ~x);
  endfunction
  logic useC; // Carry feeds the sum
  logic ci;
  logic neg; // Negate runs as 0 minus a
  logic chain; // Zero flag chains over bytes
  logic [7:0] subX;
  logic [7:0] subY;
  logic [7:0] sum;
  logic [7:0] diff;
  logic [15:0] wsum;
  logic [15:0] wdiff;
  logic zf, nf, vf, hf, cf, updZnv;
  assign chain = (opCode == OP_SUB_WITH_BORROW) ||
                 (opCode == OP_SUB_IMM_WITH_BORROW);
  assign useC = chain || (opCode == OP_ADD_CARRY);
  assign ci = useC & flagsIn[`FLAG_C];
  assign neg = (opCode == OP_TWOS_COMPLEMENT);
  assign subX = neg ? 8'h00 : a;
  assign subY = neg ? a : b;
  assign sum = a + b + {7'h00, ci};
  assign diff = subX - subY - {7'h00, ci};
  // Word immediate is six bits wide
  assign wsum = {aHi, a} + {10'h000, b[5:0]};
  assign wdiff = {aHi, a} - {10'h000, b[5:0]};
  // Result and flag selection
  always_comb begin
    res = a;
    resHi = aHi;
    wrDst = 1'b1;
    wrPair = 1'b0;
    vf = 1'b0;
    hf = flagsIn[`FLAG_H];
    cf = flagsIn[`FLAG_C];
    updZnv = 1'b1;
    case (opCode)
      OP_ADD, OP_ADD_CARRY: begin // [RQ4]
        res = sum;
        hf = addCarry(a[3], b[3], sum[3]);
        cf = addCarry(a[7], b[7], sum[7]);
        vf = (a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]);
      end
      OP_SUB, OP_SUB_IMMEDIATE, OP_SUB_WITH_BORROW,
      OP_SUB_IMM_WITH_BORROW, OP_TWOS_COMPLEMENT: begin // [RQ5] [RQ9]
        res = diff;
        hf = subBorrow(subX[3], subY[3], diff[3]);
        cf = subBorrow(subX[7], subY[7], diff[7]);
        vf = (subX[7] & ~subY[7] & ~diff[7]) |
             (~subX[7] & subY[7] & diff[7]);
      end
      OP_AND, OP_AND_IMMEDIATE: res = a & b; // [RQ7]
      OP_TEST_ZERO_MINUS: begin // [RQ11]
        res = a & b;
        wrDst = 1'b0;
      end
      OP_OR, OP_OR_IMMEDIATE, OP_SET_BITS_BY_MASK: res = a | b; // [RQ10]
      OP_CLEAR_BITS_BY_MASK: res = a & (`ALL_ONES - b); // [RQ10]
      OP_EXCLUSIVE_OR: res = a ^ b; // [RQ7]
      OP_CLEAR_REGISTER: res = a ^ a; // [RQ12]
      OP_ONES_COMPLEMENT: begin // [RQ8]
        res = `ALL_ONES - a;
        cf = 1'b1;
      end
      // Carry kept so loop counters span bytes
      OP_INC: begin // [RQ17]
        res = a + 8'h01;
        vf = (res == 8'h80);
      end
      OP_DEC: begin // [RQ17]
        res = a - 8'h01;
        vf = (res == 8'h7F);
      end
      OP_SET_REGISTER_ALL_ONES: begin // [RQ12]
        res = `ALL_ONES;
        updZnv = 1'b0;
      end
      OP_ADD_IMM_TO_PAIR: begin // [RQ6]
        {resHi, res} = wsum;
        wrDst = 1'b0;
        wrPair = 1'b1;
        vf = ~aHi[7] & wsum[15];
        cf = ~wsum[15] & aHi[7];
      end
      OP_SUB_IMM_FROM_PAIR: begin // [RQ6]
        {resHi, res} = wdiff;
        wrDst = 1'b0;
        wrPair = 1'b1;
        vf = aHi[7] & ~wdiff[15];
        cf = wdiff[15] & ~aHi[7];
      end
      default: begin // Branches and bit ops keep flags
        wrDst = 1'b0;
        updZnv = 1'b0;
      end
    endcase
    zf = wrPair ? ({resHi, res} == 16'h0000) : (res == 8'h00);
    if (chain) begin
      zf = zf & flagsIn[`FLAG_Z];
    end
    nf = wrPair ? resHi[7] : res[7];
    flagsOut = flagsIn;
    if (updZnv) begin
      flagsOut[`FLAG_Z] = zf;
      flagsOut[`FLAG_N] = nf;
      flagsOut[`FLAG_V] = vf;
      flagsOut[`FLAG_S] = nf ^ vf;
      flagsOut[`FLAG_H] = hf;
      flagsOut[`FLAG_C] = cf;
    end
  end
endmodule

/* core/pc_unit.sv */
// Next program counter and clock count per operation
`timescale 1ns/1ps
`include "alu_regs.svh"
module pc_unit (
  // Operation
  input alu_pkg::op_t opCode,
  input logic ioOk,
  // Address sources
  input logic [15:0] pc,
  input logic [15:0] relExt,
  input logic [15:0] zPtr,
  input logic [15:0] retAddr,
  // Skip decision
  input logic skipTaken,
  input logic nextTwoWord,
  // Results
  output logic [15:0] pcNext,
  output logic [2:0] cycles
);
  import alu_pkg::*;
  // Target and length selection
  always_comb begin
    pcNext = pc + `PC_STEP;
    cycles = `CYC_ONE;
    case (opCode)
      OP_RELATIVE_JUMP: begin // [RQ13]
        pcNext = pc + relExt + `PC_STEP;
        cycles = `CYC_TWO;
      end
      OP_RELATIVE_CALL: begin // [RQ13]
        pcNext = pc + relExt + `PC_STEP;
        cycles = `CYC_THREE;
      end
      OP_INDIRECT_JUMP: begin // [RQ14]
        pcNext = zPtr;
        cycles = `CYC_TWO;
      end
      OP_INDIRECT_CALL: begin // [RQ14]
        pcNext = zPtr;
        cycles = `CYC_THREE;
      end
      OP_RETURN, OP_INTERRUPT_RETURN: begin // [RQ16]
        pcNext = retAddr;
        cycles = `CYC_RET;
      end
      OP_ADD_IMM_TO_PAIR, OP_SUB_IMM_FROM_PAIR: cycles = `CYC_TWO; // [RQ6]
      // Out of range bit ops fall back to one clock
      OP_SET_IO_BIT, OP_CLEAR_IO_BIT: begin
        cycles = ioOk ? `CYC_TWO : `CYC_ONE;
      end
      OP_COMPARE_SKIP_EQUAL, OP_SKIP_IF_IO_BIT_SET,
      OP_SKIP_IF_IO_BIT_CLEAR: begin // [RQ15] [RQ3]
        if (skipTaken) begin
          pcNext = pc + (nextTwoWord ? `SKIP_TWO : `SKIP_ONE);
          cycles = nextTwoWord ? `CYC_THREE : `CYC_TWO;
        end
      end
      default: cycles = `CYC_ONE;
    endcase
  end
endmodule

/* tb/alu_and_branch_exec_tb.sv */
// Self-checking random bench for the execution datapath
`timescale 1ns/1ps
`include "alu_regs.svh"
module alu_and_branch_exec_tb;
  import alu_pkg::*;
  // Design inputs
  logic clock, rst, opValid, nextTwoWord;
  op_t opCode;
  logic [4:0] dstIdx, srcIdx, regRdIdx;
  logic [7:0] immVal, ioRdData;
  logic [1:0] pairSel;
  logic [11:0] relOfs;
  logic [5:0] ioAddr;
  logic [2:0] bitSel;
  logic [15:0] retAddr;
  // Design outputs
  logic [7:0] regRdData, statusOut;
  logic busy, opDone, ioBitSetStb, ioBitClrStb, pushStb, popStb;
  logic [15:0] pcOut, pushAddr;
  logic [5:0] ioBitAddr;
  logic [2:0] ioBitNum;
  // Reference copy of the architectural state
  logic [7:0] gpr [32];
  logic [15:0] pcM, pushA;
  logic [7:0] stM, rdExp;
  logic setE, clrE, pushE, popE;
  int nExp, miscompares, checks, cyc;
  logic [31:0] seed;
  // About 2040 ops of at most 4 clocks each, with margin
  localparam int LIMIT = 20000;

  alu_and_branch_exec DUT (.clock(clock), .rst(rst), .opValid(opValid),
    .opCode(opCode), .dstIdx(dstIdx), .srcIdx(srcIdx), .immVal(immVal),
    .pairSel(pairSel), .relOfs(relOfs), .nextTwoWord(nextTwoWord),
    .ioAddr(ioAddr), .bitSel(bitSel), .ioRdData(ioRdData),
    .retAddr(retAddr), .regRdIdx(regRdIdx), .regRdData(regRdData),
    .busy(busy), .opDone(opDone), .pcOut(pcOut), .statusOut(statusOut),
    .ioBitSetStb(ioBitSetStb), .ioBitClrStb(ioBitClrStb),
    .ioBitAddr(ioBitAddr), .ioBitNum(ioBitNum), .pushStb(pushStb),
    .pushAddr(pushAddr), .popStb(popStb));

  // Free-running core clock, 5 ns period
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  // Hang guard: a run past the ceiling counts as a failure
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      close_out();
    end
  end

  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Z, N, V and sign flag update shared by most byte ops
  function automatic logic [7:0] znvs(logic [7:0] f, logic [7:0] r,
      logic v);
    f[`FLAG_Z] = (r == 8'h00);
    f[`FLAG_N] = r[7];
    f[`FLAG_V] = v;
    f[`FLAG_S] = r[7] ^ v;
    return f;
  endfunction

  // Logic result with V cleared, packed as {flags, result}
  function automatic logic [15:0] lg(logic [7:0] f, logic [7:0] r);
    return {znvs(f, r, 1'h0), r};
  endfunction

  // Byte add or subtract with carry/borrow and half carry
  function automatic logic [15:0] arith(logic [7:0] f, logic [7:0] a,
      logic [7:0] b, logic ci, logic sub);
    logic [8:0] w;
    logic [4:0] h;
    logic v;
    if (sub) begin
      w = {1'h0, a} - {1'h0, b} - {8'h00, ci};
      h = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, ci};
      v = (a[7] ^ b[7]) & (a[7] ^ w[7]);
    end else begin
      w = {1'h0, a} + {1'h0, b} + {8'h00, ci};
      h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, ci};
      v = ~(a[7] ^ b[7]) & (a[7] ^ w[7]);
    end
    f = znvs(f, w[7:0], v);
    f[`FLAG_C] = w[8];
    f[`FLAG_H] = h[4];
    return {f, w[7:0]};
  endfunction

  // Advance the reference by the op now on the inputs
  task automatic model();
    logic [15:0] t, w, q, p;
    logic [7:0] a, b, f;
    logic [4:0] lo;
    logic c, io, skip, ad, v, pw;
    a = gpr[dstIdx];
    b = gpr[srcIdx];
    f = stM;
    c = stM[`FLAG_C];
    io = (ioAddr <= `IO_BIT_LAST);
    lo = `PAIR_BASE + {2'h0, pairSel, 1'h0};
    t = {f, a};
    q = 16'h0000;
    p = pcM + `PC_STEP;
    pushA = p;
    {skip, setE, clrE, pushE, popE, pw} = 6'h00;
    nExp = 1;
    case (opCode)
      OP_ADD: t = arith(f, a, b, 1'h0, 1'h0);
      OP_ADD_CARRY: t = arith(f, a, b, c, 1'h0);
      OP_SUB: t = arith(f, a, b, 1'h0, 1'h1);
      OP_SUB_IMMEDIATE: t = arith(f, a, immVal, 1'h0, 1'h1);
      OP_SUB_WITH_BORROW, OP_SUB_IMM_WITH_BORROW: begin
        b = (opCode == OP_SUB_WITH_BORROW) ? b : immVal;
        t = arith(f, a, b, c, 1'h1);
        // Zero flag chains across multi-byte subtracts
        t[8 + `FLAG_Z] = t[8 + `FLAG_Z] & f[`FLAG_Z];
      end
      OP_AND: t = lg(f, a & b);
      OP_AND_IMMEDIATE: t = lg(f, a & immVal);
      OP_OR: t = lg(f, a | b);
      OP_OR_IMMEDIATE, OP_SET_BITS_BY_MASK: t = lg(f, a | immVal);
      OP_EXCLUSIVE_OR: t = lg(f, a ^ b);
      OP_CLEAR_BITS_BY_MASK: t = lg(f, a & (`ALL_ONES - immVal));
      OP_ONES_COMPLEMENT: begin
        t = lg(f, `ALL_ONES - a);
        t[8 + `FLAG_C] = 1'h1;
      end
      OP_TWOS_COMPLEMENT: t = arith(f, 8'h00, a, 1'h0, 1'h1);
      OP_INC: t = {znvs(f, a + 8'h01, a == 8'h7F), a + 8'h01};
      OP_DEC: t = {znvs(f, a - 8'h01, a == 8'h80), a - 8'h01};
      OP_TEST_ZERO_MINUS: t = lg(f, a & a);
      OP_CLEAR_REGISTER: t = lg(f, a ^ a);
      OP_SET_REGISTER_ALL_ONES: t = {f, `ALL_ONES};
      OP_ADD_IMM_TO_PAIR, OP_SUB_IMM_FROM_PAIR: begin
        ad = (opCode == OP_ADD_IMM_TO_PAIR);
        w = {gpr[lo + 5'h01], gpr[lo]};
        q = ad ? w + {10'h000, immVal[5:0]} : w - {10'h000, immVal[5:0]};
        v = ad ? (~w[15] & q[15]) : (w[15] & ~q[15]);
        f[`FLAG_C] = ad ? (w[15] & ~q[15]) : (~w[15] & q[15]);
        f[`FLAG_Z] = (q == 16'h0000);
        f[`FLAG_N] = q[15];
        f[`FLAG_V] = v;
        f[`FLAG_S] = q[15] ^ v;
        t = {f, a};
        pw = 1'h1;
        nExp = 2;
      end
      OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
        p = pcM + {{4{relOfs[11]}}, relOfs} + `PC_STEP;
        pushE = (opCode == OP_RELATIVE_CALL);
        nExp = pushE ? 3 : 2;
      end
      OP_INDIRECT_JUMP, OP_INDIRECT_CALL: begin
        p = {gpr[`ZPTR_HI], gpr[`ZPTR_LO]};
        pushE = (opCode == OP_INDIRECT_CALL);
        nExp = pushE ? 3 : 2;
      end
      OP_RETURN, OP_INTERRUPT_RETURN: begin
        p = retAddr;
        popE = 1'h1;
        nExp = 4;
        t[8 + `FLAG_I] = (opCode == OP_INTERRUPT_RETURN) | f[`FLAG_I];
      end
      OP_COMPARE_SKIP_EQUAL: skip = (a == b);
      OP_SKIP_IF_IO_BIT_SET: skip = io & ioRdData[bitSel];
      OP_SKIP_IF_IO_BIT_CLEAR: skip = io & ~ioRdData[bitSel];
      OP_SET_IO_BIT, OP_CLEAR_IO_BIT: begin
        // Addresses above the bit-accessible range act as a no-op
        setE = io & (opCode == OP_SET_IO_BIT);
        clrE = io & (opCode == OP_CLEAR_IO_BIT);
        nExp = io ? 2 : 1;
      end
      default: ;
    endcase
    if (skip) begin
      p = pcM + (nextTwoWord ? `SKIP_TWO : `SKIP_ONE);
      nExp = nextTwoWord ? 3 : 2;
    end
    gpr[dstIdx] = t[7:0];
    if (pw) begin
      gpr[lo] = q[7:0];
      gpr[lo + 5'h01] = q[15:8];
    end
    stM = t[15:8];
    pcM = p;
  endtask

  // Compare one observed value with its expectation
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One cycle: check the read port, then aim it at a random register
  task automatic tick();
    @(negedge clock);
    check("regRdData", 16'(regRdData), 16'(rdExp));
    regRdIdx = 5'(rnd());
    rdExp = gpr[regRdIdx];
  endtask

  // Offer one op, then watch every cycle until it completes
  task automatic runOne(op_t o, logic [4:0] d, logic [4:0] s,
      logic [7:0] k);
    logic [31:0] r;
    int i;
    r = rnd();
    opCode = o;
    dstIdx = d;
    srcIdx = s;
    immVal = k;
    pairSel = s[1:0];
    relOfs = r[11:0];
    nextTwoWord = r[12];
    bitSel = r[15:13];
    ioAddr = r[21:16];
    ioRdData = r[29:22];
    retAddr = r[31:16];
    model();
    opValid = 1'h1;
    for (i = 1; i <= nExp; i++) begin
      tick();
      if (i == 1) begin
        check("pcOut", pcOut, pcM);
        check("statusOut", 16'(statusOut), 16'(stM));
        check("ioBitSetStb", 16'(ioBitSetStb), 16'(setE));
        check("ioBitClrStb", 16'(ioBitClrStb), 16'(clrE));
        check("pushStb", 16'(pushStb), 16'(pushE));
        check("popStb", 16'(popStb), 16'(popE));
        if (setE | clrE) begin
          check("ioBit", 16'({ioBitNum, ioBitAddr}), 16'({bitSel, ioAddr}));
        end
        if (pushE) begin
          check("pushAddr", pushAddr, pushA);
        end
      end else begin
        check("strobes", 16'({ioBitSetStb, ioBitClrStb, pushStb, popStb}), 16'h0000);
      end
      check("busy", 16'(busy), 16'(i < nExp));
      check("opDone", 16'(opDone), 16'(i == nExp));
      // Offer a different op while busy; it must be ignored
      if (i < nExp) begin
        r = rnd();
        opCode = OP_INC;
        dstIdx = r[4:0];
      end
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: reset, corner cases, every op, then random ops
  initial begin
    logic [31:0] r;
    int i;
    seed = 32'h000063F1;
    {rst, opValid, nextTwoWord} = 3'h4;
    opCode = OP_NOP;
    {dstIdx, srcIdx, regRdIdx} = 15'h0000;
    {immVal, ioRdData, pairSel, relOfs} = 30'h00000000;
    {ioAddr, bitSel, retAddr} = 25'h0000000;
    rdExp = `GPR_RST;
    pcM = `PC_RST;
    stM = `SREG_RST;
    for (i = 0; i < 32; i++) begin
      gpr[i] = `GPR_RST;
    end
    repeat (3) @(negedge clock);
    rst = 1'h0;
    // Overflow, half carry and pair wrap corners from known values
    runOne(OP_SUB_IMMEDIATE, 5'h01, 5'h00, 8'h81);
    runOne(OP_SUB_IMMEDIATE, 5'h02, 5'h00, 8'hFF);
    runOne(OP_ADD, 5'h01, 5'h02, 8'h00);
    runOne(OP_COMPARE_SKIP_EQUAL, 5'h03, 5'h04, 8'h00);
    runOne(OP_SET_REGISTER_ALL_ONES, 5'h18, 5'h00, 8'h00);
    runOne(OP_SET_REGISTER_ALL_ONES, 5'h19, 5'h00, 8'h00);
    runOne(OP_ADD_IMM_TO_PAIR, 5'h00, 5'h00, 8'h01);
    runOne(OP_SUB_IMM_FROM_PAIR, 5'h00, 5'h00, 8'h3F);
    runOne(OP_TWOS_COMPLEMENT, 5'h01, 5'h00, 8'h00);
    // Every op code once, then a long random stream
    for (i = 0; i < 2034; i++) begin
      r = rnd();
      runOne(op_t'(6'(i < 34 ? i : r % 34)), r[10:6], r[15:11], r[23:16]);
    end
    opValid = 1'h0;
    tick();
    close_out();
  end
endmodule
